// file: logic/adc_cmp_pkg.sv
// constants and types for the converter compare, trigger delay and pin disconnect block
// Function
// - with polarity clear the compare flag is high when the result is at least the compare value.
// - with polarity set the compare flag is high only when the result is below the compare value.
// - the comparator works only while its enable bit (bit 5 of control two) is 1.
// - the read-only compare flag (bit 4) is refreshed once at each conversion end.
// - with brake-on-compare (bit 7) set, a compare hit raises the fault brake; otherwise never.
// - a compare brake also clears the pwm run bit, which only software sets again.
// - the trigger delay count is nine bits: the delay byte plus bit 0 of control two as bit 8.
// - after an external trigger the start waits the delay count in converter clock periods.
// - the delay applies only to external triggers, never to software starts.
// - a set pin disable bit cuts that pin's digital input so it reads 0.
// - the result is kept as bits 11:4 in the high register and 3:0 in the low register.
// - the writable compare value is kept as bits 11:4 in its high and 3:0 in its low register.
// - conversions start by software alone, or also by the external trigger when it is enabled.
// - while busy, further external triggers are ignored.
package adc_cmp_pkg;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RES_W = 12;
    localparam int DLY_W = 9;
    localparam int PIN_W = 8;
    localparam int EVT_W = 3;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_RESULT_LOW = 8'hC2;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'hC3;
    localparam logic [7:0] OFS_COMPARE_LOW = 8'hCE;
    localparam logic [7:0] OFS_COMPARE_HIGH = 8'hCF;
    localparam logic [7:0] OFS_CONTROL_TWO = 8'hE2;
    localparam logic [7:0] OFS_DELAY_LOW = 8'hE3;
    localparam logic [7:0] OFS_PIN_DISABLE = 8'hF6;
    localparam logic [7:0] OFS_CONVERT_CTRL = 8'hD0;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'hD1;
    localparam logic [7:0] OFS_EVENT_CLEAR = 8'hD2;
    localparam logic [7:0] OFS_EVENT_ENABLE = 8'hD3;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int CONV_EXT_BIT = 0;
    localparam int CONV_START_BIT = 1;
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_HIT_BIT = 1;
    localparam int EVT_BRAKE_BIT = 2;
    localparam int NIBBLE_W = 4;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [RES_W-1:0] RST_WORD = 12'h000;
    localparam logic [DLY_W-1:0] RST_DELAY = 9'h000;
    localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    // system clocks per converter clock period
    localparam int CONV_CLK_DIV = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DELAY = 2'h1,
        ST_CONVERT = 2'h3
    } conv_state_e;

    typedef struct packed {
        logic brake_en;
        logic polarity;
        logic cmp_en;
        logic flag;
        logic [2:0] rsvd;
        logic dly8;
    } ctrl_two_s;

    typedef struct packed {
        logic done;
        logic [RES_W-1:0] data;
    } conv_result_s;

endpackage : adc_cmp_pkg

// file: logic/pin_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // pins
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage_one;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage_one <= '0;
            sync_o <= '0;
        end else begin
            stage_one <= async_i;
            sync_o <= stage_one;
        end
    end
endmodule : pin_sync

// file: logic/adc_cmp_delay.sv
// register file, single-threshold comparator, brake request and trigger delay around the converter core
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module adc_cmp_delay #(
    parameter int CLK_DIV = adc_cmp_pkg::CONV_CLK_DIV
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [adc_cmp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [adc_cmp_pkg::DATA_W-1:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [adc_cmp_pkg::DATA_W-1:0] rdata_o,
    // converter core
    output logic conv_start_o,
    input wire adc_cmp_pkg::conv_result_s conv_i,
    // external trigger, a pin
    input wire logic ext_trigger_i,
    // pwm unit
    output logic fault_brake_o,
    output logic pwm_run_clear_o,
    // analog pins, digital path
    input wire logic [adc_cmp_pkg::PIN_W-1:0] pin_in_i,
    output logic [adc_cmp_pkg::PIN_W-1:0] pin_digital_o,
    // interrupt
    output logic irq_o
);
    localparam int DIV_W = $clog2(CLK_DIV + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_DIV - 1);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [adc_cmp_pkg::PIN_W-1:0] pin_sync_q;
    logic trig_sync;
    logic trig_prev;

    pin_sync #(.W(adc_cmp_pkg::PIN_W)) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i(pin_in_i),
        .sync_o(pin_sync_q)
    );

    pin_sync #(.W(1)) u_trig_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .async_i(ext_trigger_i),
        .sync_o(trig_sync)
    );

    // ----------------------------------------
    // register state
    // ----------------------------------------
    logic [adc_cmp_pkg::RES_W-1:0] result;
    logic [adc_cmp_pkg::RES_W-1:0] compare_value;
    adc_cmp_pkg::ctrl_two_s ctrl_two;
    logic [7:0] delay_low;
    logic [adc_cmp_pkg::PIN_W-1:0] pin_digital_input_disable;
    logic external_trigger_enable;
    logic [adc_cmp_pkg::EVT_W-1:0] evt_status;
    logic [adc_cmp_pkg::EVT_W-1:0] evt_enable;
    logic [adc_cmp_pkg::RES_W-1:0] next_result;
    logic [adc_cmp_pkg::RES_W-1:0] next_compare_value;
    adc_cmp_pkg::ctrl_two_s next_ctrl_two;
    logic [7:0] next_delay_low;
    logic [adc_cmp_pkg::PIN_W-1:0] next_pin_disable;
    logic next_ext_enable;
    logic [adc_cmp_pkg::EVT_W-1:0] next_evt_status;
    logic [adc_cmp_pkg::EVT_W-1:0] next_evt_enable;
    logic [adc_cmp_pkg::DATA_W-1:0] next_rdata;

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    adc_cmp_pkg::conv_state_e state;
    adc_cmp_pkg::conv_state_e next_state;
    logic [adc_cmp_pkg::DLY_W-1:0] delay_cnt;
    logic [adc_cmp_pkg::DLY_W-1:0] next_delay_cnt;
    logic [DIV_W-1:0] div_cnt;
    logic [DIV_W-1:0] next_div_cnt;
    logic next_start;
    logic next_brake;

    logic wr_sel;
    logic sw_start;
    logic trig_edge;
    logic conv_tick;
    logic cmp_hit;
    logic [adc_cmp_pkg::DLY_W-1:0] trigger_delay_count;
    logic [adc_cmp_pkg::EVT_W-1:0] evt_set;

    assign wr_sel = write_i;
    assign sw_start = write_i && addr_i == adc_cmp_pkg::OFS_CONVERT_CTRL
                      && wdata_i[adc_cmp_pkg::CONV_START_BIT];
    assign trig_edge = trig_sync && !trig_prev;
    assign conv_tick = div_cnt == DIV_LAST;
    assign trigger_delay_count = {ctrl_two.dly8, delay_low};
    // the comparator looks at the new sample, so the flag matches the result it is stored with
    assign cmp_hit = ctrl_two.polarity ? (conv_i.data < compare_value)
                                       : (conv_i.data >= compare_value);
    assign pin_digital_o = pin_sync_q & ~pin_digital_input_disable;
    assign irq_o = |(evt_status & evt_enable);

    // ----------------------------------------
    // register file
    // ----------------------------------------
    always_comb begin
        next_result = result;
        next_compare_value = compare_value;
        next_ctrl_two = ctrl_two;
        next_delay_low = delay_low;
        next_pin_disable = pin_digital_input_disable;
        next_ext_enable = external_trigger_enable;
        next_evt_enable = evt_enable;
        next_evt_status = evt_status;
        next_rdata = adc_cmp_pkg::RST_BYTE;
        evt_set = adc_cmp_pkg::RST_EVT;
        if (wr_sel) begin
            case (addr_i)
                adc_cmp_pkg::OFS_COMPARE_HIGH: begin
                    next_compare_value[adc_cmp_pkg::RES_W-1:adc_cmp_pkg::NIBBLE_W] = wdata_i;
                end
                adc_cmp_pkg::OFS_COMPARE_LOW: begin
                    next_compare_value[adc_cmp_pkg::NIBBLE_W-1:0] =
                        wdata_i[adc_cmp_pkg::NIBBLE_W-1:0];
                end
                adc_cmp_pkg::OFS_CONTROL_TWO: begin
                    next_ctrl_two.brake_en = wdata_i[7];
                    next_ctrl_two.polarity = wdata_i[6];
                    next_ctrl_two.cmp_en = wdata_i[5];
                    next_ctrl_two.dly8 = wdata_i[0]; // flag and reserved bits stay
                end
                adc_cmp_pkg::OFS_DELAY_LOW: begin
                    next_delay_low = wdata_i;
                end
                adc_cmp_pkg::OFS_PIN_DISABLE: begin
                    next_pin_disable = wdata_i;
                end
                adc_cmp_pkg::OFS_CONVERT_CTRL: begin
                    next_ext_enable = wdata_i[adc_cmp_pkg::CONV_EXT_BIT];
                end
                adc_cmp_pkg::OFS_EVENT_CLEAR: begin
                    next_evt_status = evt_status & ~wdata_i[adc_cmp_pkg::EVT_W-1:0];
                end
                adc_cmp_pkg::OFS_EVENT_ENABLE: begin
                    next_evt_enable = wdata_i[adc_cmp_pkg::EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (conv_i.done && state == adc_cmp_pkg::ST_CONVERT) begin
            next_result = conv_i.data;
            // a disabled comparator leaves a cleared flag behind
            next_ctrl_two.flag = ctrl_two.cmp_en && cmp_hit;
            evt_set[adc_cmp_pkg::EVT_DONE_BIT] = 1'b1;
            evt_set[adc_cmp_pkg::EVT_HIT_BIT] = ctrl_two.cmp_en && cmp_hit;
        end
        evt_set[adc_cmp_pkg::EVT_BRAKE_BIT] = next_brake;
        // an event in the clearing cycle survives
        next_evt_status = next_evt_status | evt_set;
        if (read_i) begin
            case (addr_i)
                adc_cmp_pkg::OFS_RESULT_HIGH: begin
                    next_rdata = result[adc_cmp_pkg::RES_W-1:adc_cmp_pkg::NIBBLE_W];
                end
                adc_cmp_pkg::OFS_RESULT_LOW: begin
                    next_rdata = {4'h0, result[adc_cmp_pkg::NIBBLE_W-1:0]};
                end
                adc_cmp_pkg::OFS_COMPARE_HIGH: begin
                    next_rdata = compare_value[adc_cmp_pkg::RES_W-1:adc_cmp_pkg::NIBBLE_W];
                end
                adc_cmp_pkg::OFS_COMPARE_LOW: begin
                    next_rdata = {4'h0, compare_value[adc_cmp_pkg::NIBBLE_W-1:0]};
                end
                adc_cmp_pkg::OFS_CONTROL_TWO: begin
                    next_rdata = {ctrl_two.brake_en, ctrl_two.polarity, ctrl_two.cmp_en,
                                  ctrl_two.flag, 3'h0, ctrl_two.dly8};
                end
                adc_cmp_pkg::OFS_DELAY_LOW: begin
                    next_rdata = delay_low;
                end
                adc_cmp_pkg::OFS_PIN_DISABLE: begin
                    next_rdata = pin_digital_input_disable;
                end
                adc_cmp_pkg::OFS_CONVERT_CTRL: begin
                    next_rdata = {6'h00, state != adc_cmp_pkg::ST_IDLE, external_trigger_enable};
                end
                adc_cmp_pkg::OFS_EVENT_STATUS: begin
                    next_rdata = {5'h00, evt_status};
                end
                adc_cmp_pkg::OFS_EVENT_ENABLE: begin
                    next_rdata = {5'h00, evt_enable};
                end
                default: begin
                    next_rdata = adc_cmp_pkg::RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            result <= adc_cmp_pkg::RST_WORD;
            compare_value <= adc_cmp_pkg::RST_WORD;
            ctrl_two <= adc_cmp_pkg::ctrl_two_s'(adc_cmp_pkg::RST_BYTE);
            delay_low <= adc_cmp_pkg::RST_BYTE;
            pin_digital_input_disable <= adc_cmp_pkg::RST_BYTE;
            external_trigger_enable <= 1'b0;
            evt_status <= adc_cmp_pkg::RST_EVT;
            evt_enable <= adc_cmp_pkg::RST_EVT;
            rdata_o <= adc_cmp_pkg::RST_BYTE;
        end else begin
            result <= next_result;
            compare_value <= next_compare_value;
            ctrl_two <= next_ctrl_two;
            delay_low <= next_delay_low;
            pin_digital_input_disable <= next_pin_disable;
            external_trigger_enable <= next_ext_enable;
            evt_status <= next_evt_status;
            evt_enable <= next_evt_enable;
            rdata_o <= next_rdata;
        end
    end

    // ----------------------------------------
    // start sequencer and trigger delay
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_delay_cnt = delay_cnt;
        next_div_cnt = conv_tick ? '0 : div_cnt + 1'b1;
        next_start = 1'b0;
        next_brake = 1'b0;
        case (state)
            adc_cmp_pkg::ST_IDLE: begin
                if (sw_start) begin
                    next_start = 1'b1;
                    next_state = adc_cmp_pkg::ST_CONVERT;
                end else if (external_trigger_enable && trig_edge) begin
                    next_delay_cnt = trigger_delay_count;
                    next_div_cnt = '0;
                    next_state = adc_cmp_pkg::ST_DELAY;
                end
            end
            adc_cmp_pkg::ST_DELAY: begin
                // a software start overrides a pending delayed start
                if (sw_start || delay_cnt == '0) begin
                    next_start = 1'b1;
                    next_state = adc_cmp_pkg::ST_CONVERT;
                end else if (conv_tick) begin
                    next_delay_cnt = delay_cnt - 1'b1;
                end
            end
            adc_cmp_pkg::ST_CONVERT: begin
                // triggers are not looked at here; the busy bit reads 1
                if (conv_i.done) begin
                    next_state = adc_cmp_pkg::ST_IDLE;
                    next_brake = ctrl_two.brake_en && ctrl_two.cmp_en && cmp_hit;
                end
            end
            default: begin
                next_state = adc_cmp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= adc_cmp_pkg::ST_IDLE;
            delay_cnt <= adc_cmp_pkg::RST_DELAY;
            div_cnt <= '0;
            trig_prev <= 1'b0;
            conv_start_o <= 1'b0;
            fault_brake_o <= 1'b0;
            pwm_run_clear_o <= 1'b0;
        end else begin
            state <= next_state;
            delay_cnt <= next_delay_cnt;
            div_cnt <= next_div_cnt;
            trig_prev <= trig_sync;
            conv_start_o <= next_start;
            fault_brake_o <= next_brake;
            pwm_run_clear_o <= next_brake;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    logic conv_end;
    assign conv_end = conv_i.done && state == adc_cmp_pkg::ST_CONVERT;

    property p_ge_flag;
        @(posedge sys_clk_i) disable iff (reset_i)
        conv_end && ctrl_two.cmp_en && !ctrl_two.polarity && conv_i.data >= compare_value
        |=> ctrl_two.flag;
    endproperty
    a_ge_flag: assert property (p_ge_flag) else $error("flag low on result at or above compare");

    property p_lt_flag;
        @(posedge sys_clk_i) disable iff (reset_i)
        conv_end && ctrl_two.cmp_en && ctrl_two.polarity
        |=> ctrl_two.flag == ($past(conv_i.data) < $past(compare_value));
    endproperty
    a_lt_flag: assert property (p_lt_flag) else $error("inverted compare flag wrong");

    property p_cmp_off;
        @(posedge sys_clk_i) disable iff (reset_i)
        conv_end && !ctrl_two.cmp_en |=> !ctrl_two.flag && !fault_brake_o;
    endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("disabled comparator produced a hit");

    property p_flag_hold;
        @(posedge sys_clk_i) disable iff (reset_i)
        !conv_end |=> $stable(ctrl_two.flag);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag changed outside conversion end");

    property p_brake;
        @(posedge sys_clk_i) disable iff (reset_i)
        fault_brake_o |-> ctrl_two.flag && $past(ctrl_two.brake_en);
    endproperty
    a_brake: assert property (p_brake) else $error("brake without enabled compare hit");

    property p_run_clear;
        @(posedge sys_clk_i) disable iff (reset_i)
        fault_brake_o |-> pwm_run_clear_o;
    endproperty
    a_run_clear: assert property (p_run_clear) else $error("brake without run clear");

    property p_delay;
        @(posedge sys_clk_i) disable iff (reset_i)
        state == adc_cmp_pkg::ST_DELAY && delay_cnt != '0 && !sw_start |=> !conv_start_o;
    endproperty
    a_delay: assert property (p_delay) else $error("start before delay ran out");

    property p_sw_now;
        @(posedge sys_clk_i) disable iff (reset_i)
        sw_start && state != adc_cmp_pkg::ST_CONVERT |=> conv_start_o;
    endproperty
    a_sw_now: assert property (p_sw_now) else $error("software start was delayed");

    property p_pin_cut;
        @(posedge sys_clk_i) disable iff (reset_i)
        (pin_digital_o & pin_digital_input_disable) == '0;
    endproperty
    a_pin_cut: assert property (p_pin_cut) else $error("disabled pin reads high");

    property p_busy_ignore;
        @(posedge sys_clk_i) disable iff (reset_i)
        state == adc_cmp_pkg::ST_CONVERT && !conv_i.done |=> !conv_start_o;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("start while busy");

    c_delayed_start: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        state == adc_cmp_pkg::ST_DELAY ##1 conv_start_o);
    c_brake: cover property (@(posedge sys_clk_i) disable iff (reset_i) fault_brake_o);
    c_inverted_hit: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        conv_end && ctrl_two.polarity && ctrl_two.cmp_en && cmp_hit);

endmodule : adc_cmp_delay

// file: verification/conv_core_model.sv
// behavioural converter core that answers every start pulse with one result after a fixed latency
`timescale 1ns/1ps
module conv_core_model #(
    parameter int LAT = 6
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // start request and value to return
    input wire logic start_i,
    input wire logic [11:0] value_i,
    output adc_cmp_pkg::conv_result_s conv_o
);
    int cnt;

    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt <= 0;
        end else if (start_i) begin
            cnt <= LAT;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end

    // data only valid beside done; the inverse elsewhere so an early capture shows up
    assign conv_o = {cnt == 1, (cnt == 1) ? value_i : ~value_i};
endmodule : conv_core_model

// file: verification/adc_compare_delay_regs_bench.sv
// self-checking bench for the compare, trigger delay and pin disconnect block
`timescale 1ns/1ps
module adc_compare_delay_regs_bench;
    localparam int DIV = 2;
    logic sys_clk, reset, write, read, trig, conv_start, fault_brake, run_clear, irq;
    logic [7:0] addr, wdata, rdata, pin_in, pin_dig, d;
    logic [11:0] value;
    adc_cmp_pkg::conv_result_s conv;
    int n_errors, num_checks, cyc, n_start, t_start, n_brake, n_clear, t0, b0, c0, i;
    logic [7:0] a_tab [9] = '{8'hC2, 8'hC3, 8'hCE, 8'hCF, 8'hE2, 8'hE3, 8'hF6, 8'hD1, 8'h10};
    logic [7:0] e2_tab [6] = '{8'h20, 8'h20, 8'h60, 8'h60, 8'hA0, 8'h80};
    logic [11:0] v_tab [6] = '{12'hAB5, 12'hAB4, 12'hAB4, 12'hAB5, 12'hFFF, 12'hFFF};
    logic [5:0] hit = 6'b010101;

    adc_cmp_delay #(.CLK_DIV(DIV)) dut (.sys_clk_i(sys_clk), .reset_i(reset), .addr_i(addr), .wdata_i(wdata),
        .write_i(write), .read_i(read), .rdata_o(rdata), .conv_start_o(conv_start), .conv_i(conv),
        .ext_trigger_i(trig), .fault_brake_o(fault_brake), .pwm_run_clear_o(run_clear), .pin_in_i(pin_in),
        .pin_digital_o(pin_dig), .irq_o(irq));
    // long latency leaves room for a trigger edge while the conversion runs
    conv_core_model #(.LAT(16)) core (.sys_clk_i(sys_clk), .reset_i(reset), .start_i(conv_start), .value_i(value),
        .conv_o(conv));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (conv_start) begin
            n_start <= n_start + 1;
            t_start <= cyc;
        end
        if (fault_brake) n_brake <= n_brake + 1;
        if (run_clear) n_clear <= n_clear + 1;
    end

    // -------------------------------
    // bus tasks and comparison
    // -------------------------------
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        write <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        write <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        read <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        read <= 1'b0;
        #1 v = rdata;
    endtask : rd

    task chk(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a, d);
        chk(d, e);
    endtask : rchk

    // start by software write, then poll busy under a bound
    task conv_run(input logic [11:0] v, input logic [7:0] d0);
        int k;
        value <= v;
        t0 = cyc;
        wr(8'hD0, d0);
        d = 8'h02;
        for (k = 0; k < 100 && d[1]; k++) rd(8'hD0, d);
        chk(d[1], 1'b0);
        repeat (3) @(posedge sys_clk);
    endtask : conv_run

    task stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #200000;
        n_errors++;
        stop_test();
    end

    // -------------------------------
    // test sequence
    // -------------------------------
    initial begin
        reset = 1'b1;
        write = 1'b0;
        read = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        trig = 1'b0;
        pin_in = 8'hA5;
        value = 12'h000;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        for (i = 0; i < 9; i++) rchk(a_tab[i], 8'h00);
        wr(8'h10, 8'hFF);
        rchk(8'h10, 8'h00);
        wr(8'hCF, 8'hAB);
        wr(8'hCE, 8'hF5);
        rchk(8'hCF, 8'hAB);
        rchk(8'hCE, 8'h05);
        wr(8'hD3, 8'h01);
        for (i = 0; i < 6; i++) begin
            b0 = n_brake;
            c0 = n_clear;
            wr(8'hE2, e2_tab[i] | 8'h1E);
            conv_run(v_tab[i], 8'h02);
            rchk(8'hC3, v_tab[i][11:4]);
            rchk(8'hC2, {4'h0, v_tab[i][3:0]});
            rchk(8'hE2, e2_tab[i] | {3'h0, hit[i], 4'h0});
            chk(n_brake - b0, (i == 4));
            chk(n_clear - c0, (i == 4));
        end
        chk(irq, 1'b1);
        wr(8'hD2, 8'h07);
        rchk(8'hD1, 8'h00);
        chk(irq, 1'b0);
        wr(8'hD3, 8'h00);
        conv_run(12'h123, 8'h02);
        rchk(8'hD1, 8'h01);
        chk(irq, 1'b0);
        $display("test compare done");
        // count 0x105 needs bit 8 from control two
        wr(8'hE3, 8'h05);
        wr(8'hE2, 8'h01);
        wr(8'hD0, 8'h01);
        b0 = n_start;
        @(posedge sys_clk);
        trig <= 1'b1;
        t0 = cyc;
        repeat (20) @(posedge sys_clk);
        trig <= 1'b0;
        repeat (4) @(posedge sys_clk);
        trig <= 1'b1;
        for (i = 0; i < 2000 && n_start == b0; i++) @(posedge sys_clk);
        chk((t_start - t0 >= 261 * DIV) && (t_start - t0 <= 261 * DIV + DIV + 6), 1'b1);
        // a fresh trigger edge reaches the design while the conversion is still busy
        trig <= 1'b0;
        @(posedge sys_clk);
        trig <= 1'b1;
        repeat (30) @(posedge sys_clk);
        chk(n_start - b0, 1);
        trig <= 1'b0;
        conv_run(12'h000, 8'h03);
        chk(t_start - t0 <= 4, 1'b1);
        wr(8'hD0, 8'h00);
        b0 = n_start;
        trig <= 1'b1;
        repeat (20) @(posedge sys_clk);
        chk(n_start - b0, 0);
        $display("test delay done");
        chk(pin_dig, 8'hA5);
        wr(8'hF6, 8'h0F);
        rchk(8'hF6, 8'h0F);
        chk(pin_dig, 8'hA0);
        $display("test pins done");
        stop_test();
    end
endmodule : adc_compare_delay_regs_bench
